/* File: rtl/pisp_packer.sv */
// Top of the process image state packer: AXI4-Lite registers and data set image builder.
// Assumes logic inputs are on core_clk_in and cycle_tick_in marks each network cycle.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module pisp_packer
   import pisp_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Controller logic side
   input wire pisp_logic_type logic_in,
   input wire logic [NUM_MODULES-1:0][3:0] in_pair_ok_in,
   input wire logic cycle_tick_in,
   input wire logic comm_err_in,
   // Image to network side
   output logic [DS1_BYTES-1:0][7:0] ds1_out,
   output logic [DS2_BYTES-1:0][7:0] ds2_out,
   output logic image_valid_out,
   output logic comm_ok_out,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt
   output logic irq_out
);
   logic [31:0] ctrl;
   logic [5:0] direct_cnt;
   logic [5:0] direct_pos;
   logic [5:0] state_pos;
   logic [NUM_MODULES-1:0][3:0] dual_in;
   logic [NUM_MODULES-1:0][3:0] dual_out;
   logic [DS1_BYTES-1:0][7:0] direct;
   logic [DS2_BYTES-1:0][7:0] ds2_reg;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [15:0] cycles;
   logic [7:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   logic [NUM_MODULES-1:0][7:0] in_enc;
   logic [NUM_MODULES-1:0][7:0] out_enc;
   logic [15:0] in_word;
   logic [15:0] out_word;
   logic [DS1_BYTES-1:0][7:0] next_ds1;
   logic wr_fire;
   logic [31:0] rd_val;
   logic rd_ok;

   // Per-module pair encoding
   for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
      pisp_pair_enc u_in_enc (
         .pair_in(pisp_pair_type'{byte_val: logic_in.in_val[m], pair_ok: in_pair_ok_in[m], dual_cfg: dual_in[m]}),
         .is_output_in(1'b0),
         .byte_out(in_enc[m])
      );
      pisp_pair_enc u_out_enc (
         .pair_in(pisp_pair_type'{byte_val: logic_in.out_val[m], pair_ok: 4'h0, dual_cfg: dual_out[m]}),
         .is_output_in(1'b1),
         .byte_out(out_enc[m])
      );
   end

   pisp_state_word u_in_word (
      .mod_ok_in(logic_in.in_ok),
      .gw_ok_in(logic_in.gw_in_ok),
      .word_out(in_word)
   );
   pisp_state_word u_out_word (
      .mod_ok_in(logic_in.out_ok),
      .gw_ok_in(logic_in.gw_out_ok),
      .word_out(out_word)
   );

   // Data set one assembly, default layout
   always_comb begin
      logic [5:0] k;
      k = 6'h00;
      next_ds1 = '0;
      next_ds1[POS_CTRL_IN0] = in_enc[0];
      next_ds1[POS_CTRL_IN1] = 8'h00;
      next_ds1[POS_CTRL_IN2] = 8'h00;
      next_ds1[POS_CTRL_OUT] = out_enc[0];
      for (int m = 1; m < NUM_MODULES; m++) begin
         next_ds1[POS_EXP_IN + 6'(m - 1)] = in_enc[m];
         next_ds1[POS_EXP_OUT + 6'(m - 1)] = out_enc[m];
      end
      // Collective state: input word then output word, low byte first
      if (ctrl[CTRL_STATE_EN_BIT] && state_pos <= 6'(DS1_BYTES - STATE_BYTES)) begin
         next_ds1[state_pos] = in_word[7:0];
         next_ds1[state_pos + 6'h01] = in_word[15:8];
         next_ds1[state_pos + 6'h02] = out_word[7:0];
         next_ds1[state_pos + 6'h03] = out_word[15:8];
      end
      // Direct bytes override, up to the full data set
      for (int i = 0; i < DS1_BYTES; i++) begin
         k = 6'(i);
         if (k >= direct_pos && (k - direct_pos) < direct_cnt) begin
            next_ds1[i] = direct[k - direct_pos];
         end
      end
   end

   // Atomic image refresh, once per network cycle
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ds1_out <= '0;
         ds2_out <= '0;
         image_valid_out <= 1'b0;
         comm_ok_out <= 1'b0;
      end else if (comm_err_in || !ctrl[CTRL_ENABLE_BIT]) begin
         ds1_out <= '0;
         ds2_out <= '0;
         image_valid_out <= 1'b0;
         comm_ok_out <= 1'b0;
      end else if (cycle_tick_in) begin
         ds1_out <= next_ds1;
         ds2_out <= ds2_reg;
         image_valid_out <= 1'b1;
         comm_ok_out <= 1'b1;
      end
   end

   // Cycle counter, readable state
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cycles <= 16'h0000;
      end else if (cycle_tick_in && !comm_err_in) begin
         cycles <= cycles + 16'h0001;
      end
   end

   // AXI write channel capture
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr < REG_DS2_BASE + 8'(4 * DS2_BYTES / 4)) ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register writes
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ctrl <= CTRL_RESET;
         direct_cnt <= DIRECT_CNT_RESET;
         direct_pos <= POS_DIRECT_DEF;
         state_pos <= POS_STATE_DEF;
         dual_in <= '0;
         dual_out <= '0;
         direct <= '0;
         ds2_reg <= '0;
         irq_mask <= 2'h0;
      end else if (wr_fire) begin
         for (int b = 0; b < 4; b++) begin
            if (w_strb[b]) begin
               if (aw_addr >= REG_DIRECT_BASE && aw_addr < REG_DS2_BASE
                   && 8'(aw_addr - REG_DIRECT_BASE + 8'(b)) < 8'(DS1_BYTES)) begin
                  direct[6'(aw_addr - REG_DIRECT_BASE + 8'(b))] <= w_data[8*b +: 8];
               end
               // Refused addresses past data set two must not alias into it
               if (aw_addr >= REG_DS2_BASE && aw_addr < REG_DS2_BASE + 8'(DS2_BYTES)) begin
                  ds2_reg[5'(aw_addr - REG_DS2_BASE + 8'(b))] <= w_data[8*b +: 8];
               end
            end
         end
         unique case (aw_addr)
            REG_CTRL: ctrl <= w_data;
            REG_IRQ_MASK: irq_mask <= w_data[1:0];
            REG_DIRECT_CNT: direct_cnt <= (w_data[5:0] > 6'(DS1_BYTES)) ? 6'(DS1_BYTES) : w_data[5:0];
            REG_DIRECT_POS: direct_pos <= w_data[5:0];
            REG_STATE_POS: state_pos <= w_data[5:0];
            // Only modules 0 to 7 fit one word; later modules stay single-channel
            REG_DUAL_IN: dual_in <= {20'h0_0000, w_data};
            REG_DUAL_OUT: dual_out <= {20'h0_0000, w_data};
            default: ;
         endcase
      end
   end

   // Sticky interrupt status, set wins over write-one-to-clear
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         irq_stat <= 2'h0;
         irq_out <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_fire && aw_addr == REG_IRQ_STAT && w_strb[0] && w_data[i]) begin
               irq_stat[i] <= 1'b0;
            end
         end
         if (cycle_tick_in && !comm_err_in && ctrl[CTRL_ENABLE_BIT]) begin
            irq_stat[IRQ_CYCLE_BIT] <= 1'b1;
         end
         if (comm_err_in) begin
            irq_stat[IRQ_COMM_ERR_BIT] <= 1'b1;
         end
         irq_out <= |(irq_stat & irq_mask);
      end
   end

   // Read path
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_ok = 1'b1;
      if (s_axi_araddr >= REG_DS2_BASE) begin
         if (s_axi_araddr < REG_DS2_BASE + 8'(DS2_BYTES)) begin
            rd_val = ds2_reg[3'(s_axi_araddr[4:2])*4 +: 4];
         end else begin
            rd_ok = 1'b0;
         end
      end else if (s_axi_araddr >= REG_DIRECT_BASE) begin
         if (s_axi_araddr < REG_DIRECT_BASE + 8'(DS1_BYTES)) begin
            for (int b = 0; b < 4; b++) begin
               if (6'(s_axi_araddr[5:2]) * 6'h04 + 6'(b) < 6'(DS1_BYTES)) begin
                  rd_val[8*b +: 8] = direct[6'(s_axi_araddr[5:2]) * 6'h04 + 6'(b)];
               end
            end
         end else begin
            rd_ok = 1'b0;
         end
      end else begin
         unique case (s_axi_araddr)
            REG_CTRL: rd_val = ctrl;
            REG_STATUS: rd_val = {out_word, in_word};
            REG_IRQ_STAT: rd_val = {30'h0, irq_stat};
            REG_IRQ_MASK: rd_val = {30'h0, irq_mask};
            REG_DIRECT_CNT: rd_val = {26'h0, direct_cnt};
            REG_DIRECT_POS: rd_val = {26'h0, direct_pos};
            REG_STATE_POS: rd_val = {26'h0, state_pos};
            REG_DUAL_IN: rd_val = dual_in[7:0];
            REG_DUAL_OUT: rd_val = dual_out[7:0];
            REG_CYCLES: rd_val = {14'h0, comm_ok_out, image_valid_out, cycles};
            default: rd_ok = 1'b0;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= AXI_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : pisp_packer

/* File: rtl/pisp_pkg.sv */
// Package for the process image state packer: byte map, field layouts, register map.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register master.
package pisp_pkg;
   localparam int unsigned DS1_BYTES = 50;
   localparam int unsigned DS1_BLOCKS = 5;
   localparam int unsigned DS1_BLOCK_BYTES = 10;
   localparam int unsigned DS2_BYTES = 32;
   localparam int unsigned NUM_MODULES = 13;
   localparam int unsigned DIRECT_DEFAULT = 4;
   localparam int unsigned STATE_BYTES = 4;
   // Default byte positions inside data set one
   localparam logic [5:0] POS_CTRL_IN0 = 6'h00;
   localparam logic [5:0] POS_CTRL_IN1 = 6'h01;
   localparam logic [5:0] POS_CTRL_IN2 = 6'h02;
   localparam logic [5:0] POS_CTRL_OUT = 6'h03;
   localparam logic [5:0] POS_EXP_IN = 6'h0c;
   localparam logic [5:0] POS_EXP_OUT = 6'h18;
   localparam logic [5:0] POS_DIRECT_DEF = 6'h24;
   localparam logic [5:0] POS_STATE_DEF = 6'h28;
   localparam logic [5:0] POS_DISABLED = 6'h3f;
   // Source selector codes; no per-byte map in the packer uses them
   localparam logic [2:0] SRC_ZERO = 3'h0;
   localparam logic [2:0] SRC_IN = 3'h1;
   localparam logic [2:0] SRC_OUT = 3'h2;
   localparam logic [2:0] SRC_DIRECT = 3'h3;
   localparam logic [2:0] SRC_STATE = 3'h4;
   // Register map (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
   localparam logic [7:0] REG_DIRECT_CNT = 8'h10;
   localparam logic [7:0] REG_DIRECT_POS = 8'h14;
   localparam logic [7:0] REG_STATE_POS = 8'h18;
   localparam logic [7:0] REG_DUAL_IN = 8'h1c;
   localparam logic [7:0] REG_DUAL_OUT = 8'h20;
   localparam logic [7:0] REG_CYCLES = 8'h24;
   localparam logic [7:0] REG_DIRECT_BASE = 8'h40;
   localparam logic [7:0] REG_DS2_BASE = 8'h80;
   // Control fields
   localparam int unsigned CTRL_ENABLE_BIT = 0;
   localparam int unsigned CTRL_STATE_EN_BIT = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
   localparam logic [5:0] DIRECT_CNT_RESET = 6'h04;
   // Interrupt status bits
   localparam int unsigned IRQ_CYCLE_BIT = 0;
   localparam int unsigned IRQ_COMM_ERR_BIT = 1;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef struct packed {
      logic [NUM_MODULES-1:0][7:0] in_val;
      logic [NUM_MODULES-1:0][7:0] out_val;
      logic [NUM_MODULES-1:0] in_ok;
      logic [NUM_MODULES-1:0] out_ok;
      logic [1:0] gw_in_ok;
      logic [1:0] gw_out_ok;
   } pisp_logic_type;

   typedef struct packed {
      logic [7:0] byte_val;
      logic [3:0] pair_ok;
      logic [3:0] dual_cfg;
   } pisp_pair_type;
endpackage : pisp_pkg

/* File: rtl/pisp_pair_enc.sv */
// Two-channel encoder for one module byte.
// Assumes pair_ok from the controller's two-channel evaluation on the same clock.
`timescale 1ns/1ps
module pisp_pair_enc
   import pisp_pkg::*;
(
   // Pair data
   input wire pisp_pair_type pair_in,
   input wire logic is_output_in,
   // Encoded byte
   output logic [7:0] byte_out
);
   always_comb begin
      byte_out = pair_in.byte_val;
      for (int p = 0; p < 4; p++) begin
         if (pair_in.dual_cfg[p]) begin
            byte_out[2*p] = pair_in.byte_val[2*p];
            if (is_output_in) begin
               byte_out[2*p+1] = 1'b0;
            end else begin
               byte_out[2*p+1] = pair_in.pair_ok[p];
            end
         end
      end
   end
endmodule : pisp_pair_enc

/* File: rtl/pisp_state_word.sv */
// Builds one sixteen-bit collective state word from per-module ok flags.
// Assumes flags are one when the module side is error free.
`timescale 1ns/1ps
module pisp_state_word
   import pisp_pkg::*;
(
   // Flags
   input wire logic [NUM_MODULES-1:0] mod_ok_in,
   input wire logic [1:0] gw_ok_in,
   // Word
   output logic [15:0] word_out
);
   // Reserved bit kept at zero; no module drives it
   assign word_out = {1'b0, gw_ok_in, mod_ok_in};
endmodule : pisp_state_word

/* File: verif/pisp_packer_properties.sv */
// Port checks for the packer: image refresh, error clearing, AXI4-Lite answers.
// Assumes one clock and the synchronous active-high reset of the packer.
`timescale 1ns/1ps
module pisp_packer_checker
   import pisp_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Image side
   input wire logic cycle_tick_in,
   input wire logic comm_err_in,
   input wire logic [DS1_BYTES-1:0][7:0] ds1_out,
   input wire logic image_valid_out,
   input wire logic comm_ok_out,
   // AXI4-Lite
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   err_clear_a: assert property (comm_err_in |=> ds1_out == '0 && !image_valid_out && !comm_ok_out)
      else $error("image not cleared after communication error");
   tick_rise_a: assert property ($rose(image_valid_out) |-> $past(cycle_tick_in) && !$past(comm_err_in))
      else $error("image became valid without a cycle tick");
   image_hold_a: assert property (image_valid_out && $past(image_valid_out) && !$past(cycle_tick_in)
      |-> $stable(ds1_out))
      else $error("image changed between ticks");
   zero_bytes_a: assert property (image_valid_out |-> ds1_out[1] == 8'h00 && ds1_out[2] == 8'h00)
      else $error("unassigned byte not zero");
   res_bit_a: assert property (image_valid_out |-> !ds1_out[41][7] && !ds1_out[43][7])
      else $error("reserved state bit set");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   write_answer_a: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
      else $error("write response missing");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'ha0
      |=> s_axi_rvalid && s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   cover property (comm_err_in ##1 !comm_err_in);
   cover property ($rose(image_valid_out));
   cover property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR);
endmodule : pisp_packer_checker

bind pisp_packer pisp_packer_checker chk_u (.core_clk_in, .rst_in, .cycle_tick_in, .comm_err_in, .ds1_out,
   .image_valid_out, .comm_ok_out, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

/* File: verif/pisp_net_master.sv */
// Network master model: issues cycle ticks at varying gaps and reads the image.
// Assumes the packer answers one cycle after each tick.
`timescale 1ns/1ps
module pisp_net_master
   import pisp_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Image side
   input wire logic run_in,
   input wire logic [DS1_BYTES-1:0][7:0] ds1_in,
   output logic tick_out,
   output logic [DS1_BYTES-1:0][7:0] rx_image_out,
   output logic [15:0] frames_out
);
   logic [4:0] gap;
   logic tick_d;
   // Gap varies so refreshes come both promptly and slowly
   always_ff @(posedge core_clk_in) begin
      if (rst_in || !run_in) begin
         gap <= 5'h08;
         tick_out <= 1'h0;
      end else begin
         tick_out <= (gap == 5'h00);
         gap <= (gap == 5'h00) ? {2'h1, frames_out[2:0]} : gap - 5'h01;
      end
   end
   // Whole image taken one cycle after the tick
   always_ff @(posedge core_clk_in) begin
      tick_d <= tick_out;
      if (rst_in) begin
         frames_out <= 16'h0000;
         rx_image_out <= '0;
      end else if (tick_d) begin
         frames_out <= frames_out + 16'h0001;
         rx_image_out <= ds1_in;
      end
   end
endmodule : pisp_net_master

/* File: verif/tb_top.sv */
// Self-checking bench for the packer with a network master model on the image side.
// Assumes the package, design, checker and master model are compiled before it.
`timescale 1ns/1ps
module tb_top
   import pisp_pkg::*;
;
   logic core_clk_in = 1'h0;
   logic rst_in = 1'h1;
   logic comm_err_in = 1'h0;
   logic run = 1'h0;
   logic cycle_tick_in, image_valid_out, comm_ok_out, irq_out;
   pisp_logic_type logic_in = '0;
   logic [NUM_MODULES-1:0][3:0] in_pair_ok_in = '0;
   logic [DS1_BYTES-1:0][7:0] ds1_out, rx_img;
   logic [DS2_BYTES-1:0][7:0] ds2_out;
   logic [15:0] frames;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int errors = 0, tests_run = 0, cyc = 0, seed = 33;

   always #4 core_clk_in = ~core_clk_in;

   pisp_packer dut_u (.core_clk_in, .rst_in, .logic_in, .in_pair_ok_in, .cycle_tick_in, .comm_err_in, .ds1_out,
      .ds2_out, .image_valid_out, .comm_ok_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_out);
   pisp_net_master net_u (.core_clk_in, .rst_in, .run_in(run), .ds1_in(ds1_out), .tick_out(cycle_tick_in),
      .rx_image_out(rx_img), .frames_out(frames));

   function automatic logic [255:0] rnd();
      logic [255:0] t;
      for (int k = 0; k < 8; k++) t[32*k+:32] = $random(seed);
      return t;
   endfunction : rnd

   function automatic logic [15:0] sw(input logic [12:0] ok, input logic [1:0] g);
      return {1'h0, g, ok};
   endfunction : sw

   function automatic logic [7:0] enc(input logic [7:0] v, input logic [3:0] ok, cfg, input logic q);
      logic [7:0] b;
      b = v;
      for (int p = 0; p < 4; p++) if (cfg[p]) b[2*p+1] = q ? 1'h0 : ok[p];
      return b;
   endfunction : enc

   function automatic logic [DS1_BYTES-1:0][7:0] exp_img(input pisp_logic_type l,
         input logic [NUM_MODULES-1:0][3:0] pk, input logic [31:0] di, dq, dw, input logic st);
      logic [DS1_BYTES-1:0][7:0] e;
      e = '0;
      for (int m = 0; m < NUM_MODULES; m++) begin
         e[m == 0 ? 0 : 11 + m] = enc(l.in_val[m], pk[m], m < 8 ? di[4*m+:4] : 4'h0, 1'h0);
         e[m == 0 ? 3 : 23 + m] = enc(l.out_val[m], 4'h0, m < 8 ? dq[4*m+:4] : 4'h0, 1'h1);
      end
      if (st) e[43:40] = {sw(l.out_ok, l.gw_out_ok), sw(l.in_ok, l.gw_in_ok)};
      e[39:36] = dw;
      return e;
   endfunction : exp_img

   task automatic chk(input logic [511:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      @(posedge core_clk_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge core_clk_in);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      @(posedge core_clk_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge core_clk_in);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : axr

   // Two frames, since the first may have been latched before the last write landed
   task automatic wait_frames();
      logic [15:0] f;
      f = frames;
      while (frames < f + 16'h0002) @(posedge core_clk_in);
   endtask : wait_frames

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge core_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         report_and_stop();
      end
   end

   initial begin
      logic [31:0] d, di, dq, dw;
      logic [1:0] r;
      logic [255:0] t;
      static logic [7:0] ra[4] = '{REG_CTRL, REG_DIRECT_CNT, REG_DIRECT_POS, REG_STATE_POS};
      static logic [31:0] rv[4] = '{CTRL_RESET, 32'h4, 32'h24, 32'h28};
      static logic [7:0] ia[3] = '{REG_IRQ_MASK, REG_IRQ_MASK, REG_IRQ_STAT};
      static logic [31:0] id[3] = '{32'h0, 32'h2, 32'h2};
      static logic ie[3] = '{1'h0, 1'h1, 1'h0};
      repeat (16) @(posedge core_clk_in);
      rst_in <= 1'h0;
      foreach (ra[i]) begin
         axr(ra[i], d, r);
         chk(d, rv[i]);
      end
      axr(8'ha0, d, r);
      chk({r, d}, {AXI_SLVERR, 32'h0});
      axw(8'ha4, 32'h1234_5678, r);
      chk(r, AXI_SLVERR);
      axw(REG_DIRECT_CNT, 32'h3f, r);
      axr(REG_DIRECT_CNT, d, r);
      chk(d, 32'h32);
      axw(REG_DIRECT_CNT, 32'h4, r);
      run <= 1'h1;
      for (int i = 0; i < 8; i++) begin
         t = rnd();
         logic_in <= t[$bits(pisp_logic_type)-1:0];
         t = rnd();
         in_pair_ok_in <= t[51:0];
         di = (i == 0) ? 32'hffff_ffff : t[83:52];
         dq = (i == 0) ? 32'hffff_ffff : t[115:84];
         dw = t[147:116];
         axw(REG_DUAL_IN, di, r);
         axw(REG_DUAL_OUT, dq, r);
         axw(REG_DIRECT_BASE, dw, r);
         axw(REG_CTRL, {30'h0, i != 3, 1'h1}, r);
         wait_frames();
         chk(rx_img, exp_img(logic_in, in_pair_ok_in, di, dq, dw, i != 3));
         chk({comm_ok_out, image_valid_out}, 2'h3);
         axr(REG_STATUS, d, r);
         chk(d, {sw(logic_in.out_ok, logic_in.gw_out_ok), sw(logic_in.in_ok, logic_in.gw_in_ok)});
      end
      axw(REG_DS2_BASE, dw, r);
      wait_frames();
      chk(ds2_out[7:0], {32'h0, dw});
      axw(REG_IRQ_MASK, 32'h2, r);
      comm_err_in <= 1'h1;
      repeat (3) @(posedge core_clk_in);
      chk({ds1_out, image_valid_out, comm_ok_out, irq_out}, 1'h1);
      comm_err_in <= 1'h0;
      foreach (ia[i]) begin
         axw(ia[i], id[i], r);
         repeat (2) @(posedge core_clk_in);
         chk(irq_out, ie[i]);
      end
      // State words that would run past the last byte are refused
      axw(REG_STATE_POS, 32'h2f, r);
      wait_frames();
      chk(rx_img, exp_img(logic_in, in_pair_ok_in, di, dq, dw, 1'h0));
      chk(image_valid_out, 1'h1);
      report_and_stop();
   end
endmodule : tb_top
